// File: pkg/pcpsr_pkg.sv
package pcpsr_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PWR_W  = 24;
  localparam int SUM_W  = PWR_W + 2;
  localparam int CODE_W = 10;
  localparam int SIGN_W = 9;
  localparam int CFG_W  = 19;

  // ----------------------------------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_PHASE_A_COMP = 16'hE614;
  localparam logic [15:0] IDX_PHASE_B_COMP = 16'hE615;
  localparam logic [15:0] IDX_PHASE_C_COMP = 16'hE616;
  localparam logic [15:0] IDX_POWER_SIGN   = 16'hE617;
  localparam logic [15:0] IDX_PATH_CFG     = 16'hE620;
  localparam logic [15:0] IDX_IRQ_STATUS   = 16'hE621;
  localparam logic [15:0] IDX_IRQ_MASK     = 16'hE622;

  // ----------------------------------------------------------------
  // delay code ranges
  // ----------------------------------------------------------------
  localparam logic [CODE_W-1:0] CODE_LEAD_MAX   = 10'h17F;
  localparam logic [CODE_W-1:0] CODE_FOLD1_MAX  = 10'h1FF;
  localparam logic [CODE_W-1:0] CODE_LAG_MIN    = 10'h200;
  localparam logic [CODE_W-1:0] CODE_LAG_MAX    = 10'h23F;
  localparam logic [CODE_W-1:0] CODE_FOLD2_MIN  = 10'h240;
  localparam logic [CODE_W-1:0] CODE_FOLD_SHIFT = 10'h080;
  localparam logic [CODE_W-1:0] CODE_FOLD2_BASE = 10'h180;
  localparam logic [CODE_W-1:0] COMP_RESET      = 10'h000;

  // ----------------------------------------------------------------
  // path source select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SRC_TOTAL_ACT  = 3'h0;
  localparam logic [2:0] SRC_APPARENT   = 3'h2;
  localparam logic [2:0] SRC_FUND_ACT   = 3'h3;
  localparam logic [2:0] SRC_FUND_REACT = 3'h4;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_ACT0   = 0;
  localparam int BIT_PATH1  = 3;
  localparam int BIT_REACT0 = 4;
  localparam int BIT_PATH2  = 7;
  localparam int BIT_PATH3  = 8;
  localparam int CFG_TERMS_LSB = 0;
  localparam int CFG_SRC_LSB   = 9;
  localparam int CFG_REV_BIT   = 18;
  localparam logic [CFG_W-1:0]  CFG_RESET  = 19'h141FF;
  localparam logic [SIGN_W-1:0] SIGN_RESET = 9'h000;

  typedef struct packed {
    logic signed [PWR_W-1:0] total_active;
    logic signed [PWR_W-1:0] fund_active;
    logic signed [PWR_W-1:0] fund_reactive;
    logic signed [PWR_W-1:0] apparent;
  } pcpsr_phase_pwr_t;

endpackage : pcpsr_pkg

// File: design/pcpsr_regs.sv
// The APB register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// [R1] delay code is 10 bits; leading current uses codes 0 to 383
// [R2] lagging current uses delay codes 512 to 575
// [R3] codes 384 to 511 act as the code minus 128
// [R4] codes 576 to 1023 fold into 384 to 511, keeping the offset modulo 128
// [R5] upper six compensation bits do nothing and reset to zero
// [R6] status bits 0..2 are active power signs of phases A..C
// [R7] active sign follows total or fundamental power per reversal select
// [R8] status bits 4..6 are fundamental reactive power signs A..C
// [R9] status bit 3 is the sign of the path 1 sum
// [R10] status bit 7 is the sign of the path 2 sum
// [R11] status bit 8 is the sign of the path 3 sum
// [R12] status bits 15..9 read zero; sign bits reset to zero
// [R13] source select: 000 total, 010 apparent, 011 fund active, 100 reactive
// [R14] sign status is read-only and updates on each datapath refresh
// [R15] compensation registers read back; reserved bits ignored and read zero
module pcpsr_regs #(
  parameter int ADDR_W = 18
) (
  input  wire logic                                clk,
  input  wire logic                                rst_n,
  input  wire logic                                ce,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [ADDR_W-1:0]                   paddr,
  input  wire logic [31:0]                         pwdata,
  output logic      [31:0]                         prdata_q,
  output logic                                     pready_q,
  output logic                                     pslverr_q,
  input  wire pcpsr_pkg::pcpsr_phase_pwr_t [2:0]   phase_pwr,
  input  wire logic                                pwr_valid,
  output logic      [2:0][pcpsr_pkg::CODE_W-1:0]   eff_delay_code_q,
  output logic      [pcpsr_pkg::SIGN_W-1:0]        power_sign_q,
  output logic                                     irq_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [2:0][pcpsr_pkg::CODE_W-1:0] delay_code_q;
  logic [pcpsr_pkg::CFG_W-1:0]       path_cfg_q;
  logic [pcpsr_pkg::SIGN_W-1:0]      irq_status_q;
  logic [pcpsr_pkg::SIGN_W-1:0]      irq_status_d;
  logic [pcpsr_pkg::SIGN_W-1:0]      irq_mask_q;
  logic [pcpsr_pkg::SIGN_W-1:0]      sign_d;
  logic [2:0]                        act_neg;
  logic [2:0]                        react_neg;
  logic [2:0]                        path_neg;
  logic [2:0][pcpsr_pkg::CODE_W-1:0] fold_code;
  logic [15:0]                       idx;
  logic                              setup;
  logic                              wr_en;
  logic                              mapped;
  logic [31:0]                       rd_mux;
  logic                              rev_fund;

  assign idx      = paddr[ADDR_W-1:2];
  assign setup    = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & pready_q;
  assign rev_fund = path_cfg_q[pcpsr_pkg::CFG_REV_BIT];

  // ----------------------------------------------------------------
  // path sum helper
  // ----------------------------------------------------------------
  function automatic logic signed [pcpsr_pkg::SUM_W-1:0] path_sum(
    input logic [2:0]                            terms,
    input logic [2:0]                            src,
    input pcpsr_pkg::pcpsr_phase_pwr_t [2:0]     pw
  );
    logic signed [pcpsr_pkg::SUM_W-1:0] acc;
    logic        [pcpsr_pkg::PWR_W-1:0] v;
    acc = '0;
    v   = '0;
    for (int i = 0; i < 3; i++)
    begin
      case (src)
        pcpsr_pkg::SRC_TOTAL_ACT:  v = pw[i].total_active;
        pcpsr_pkg::SRC_APPARENT:   v = pw[i].apparent;
        pcpsr_pkg::SRC_FUND_ACT:   v = pw[i].fund_active;
        pcpsr_pkg::SRC_FUND_REACT: v = pw[i].fund_reactive;
        default:                   v = '0;
      endcase
      if (terms[i])
      begin
        acc = acc + $signed({{2{v[pcpsr_pkg::PWR_W-1]}}, v});
      end
    end
    return acc;
  endfunction : path_sum

  // ----------------------------------------------------------------
  // per-phase folding and signs
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++)
    begin : g_phase
      logic [pcpsr_pkg::CODE_W-1:0]      c;
      logic [pcpsr_pkg::CODE_W-1:0]      off;
      logic signed [pcpsr_pkg::SUM_W-1:0] s;
      logic [pcpsr_pkg::CODE_W-1:0]      f;
      assign c   = delay_code_q[p];
      assign off = c - pcpsr_pkg::CODE_FOLD2_MIN;
      always_comb
      begin
        if (c <= pcpsr_pkg::CODE_LEAD_MAX)  // [R1]
          f = c;
        else if (c <= pcpsr_pkg::CODE_FOLD1_MAX)
          f = c - pcpsr_pkg::CODE_FOLD_SHIFT;  // [R3]
        else if (c <= pcpsr_pkg::CODE_LAG_MAX)
          f = c;  // [R2]
        else
          f = pcpsr_pkg::CODE_FOLD2_BASE | {3'h0, off[6:0]};  // [R4]
      end
      assign fold_code[p] = f;
      // sign of selected active power
      assign act_neg[p]   = rev_fund ? phase_pwr[p].fund_active[pcpsr_pkg::PWR_W-1]
                                     : phase_pwr[p].total_active[pcpsr_pkg::PWR_W-1];  // [R6] [R7]
      assign react_neg[p] = phase_pwr[p].fund_reactive[pcpsr_pkg::PWR_W-1];  // [R8]
      assign s = path_sum(path_cfg_q[pcpsr_pkg::CFG_TERMS_LSB + 3*p +: 3],
                          path_cfg_q[pcpsr_pkg::CFG_SRC_LSB + 3*p +: 3], phase_pwr);  // [R13]
      assign path_neg[p] = s[pcpsr_pkg::SUM_W-1];
    end
  endgenerate

  always_comb
  begin
    sign_d = '0;
    sign_d[pcpsr_pkg::BIT_ACT0 +: 3]   = act_neg;
    sign_d[pcpsr_pkg::BIT_REACT0 +: 3] = react_neg;
    sign_d[pcpsr_pkg::BIT_PATH1]       = path_neg[0];  // [R9]
    sign_d[pcpsr_pkg::BIT_PATH2]       = path_neg[1];  // [R10]
    sign_d[pcpsr_pkg::BIT_PATH3]       = path_neg[2];  // [R11]
  end

  // ----------------------------------------------------------------
  // compensation registers and effective codes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      delay_code_q <= {3{pcpsr_pkg::COMP_RESET}};
    else if (ce && wr_en)
    begin
      if (idx == pcpsr_pkg::IDX_PHASE_A_COMP)
        delay_code_q[0] <= pwdata[pcpsr_pkg::CODE_W-1:0];  // [R15] [R5]
      if (idx == pcpsr_pkg::IDX_PHASE_B_COMP)
        delay_code_q[1] <= pwdata[pcpsr_pkg::CODE_W-1:0];  // [R15] [R5]
      if (idx == pcpsr_pkg::IDX_PHASE_C_COMP)
        delay_code_q[2] <= pwdata[pcpsr_pkg::CODE_W-1:0];  // [R15] [R5]
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      eff_delay_code_q <= {3{pcpsr_pkg::COMP_RESET}};
    else if (ce)
      eff_delay_code_q <= fold_code;
  end

  // ----------------------------------------------------------------
  // path configuration
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      path_cfg_q <= pcpsr_pkg::CFG_RESET;
    else if (ce && wr_en && idx == pcpsr_pkg::IDX_PATH_CFG)
      path_cfg_q <= pwdata[pcpsr_pkg::CFG_W-1:0];
  end

  // ----------------------------------------------------------------
  // sign status, refreshed by the datapath only
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      power_sign_q <= pcpsr_pkg::SIGN_RESET;  // [R12]
    else if (ce && pwr_valid)
      power_sign_q <= sign_d;  // [R14]
  end

  // ----------------------------------------------------------------
  // interrupts: sign change events, set wins over clear
  // ----------------------------------------------------------------
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (wr_en && idx == pcpsr_pkg::IDX_IRQ_STATUS)
      irq_status_d = irq_status_d & ~pwdata[pcpsr_pkg::SIGN_W-1:0];
    if (pwr_valid)
      irq_status_d = irq_status_d | (sign_d ^ power_sign_q);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_status_q <= '0;
      irq_mask_q   <= '0;
      irq_q        <= 1'b0;
    end
    else if (ce)
    begin
      irq_status_q <= irq_status_d;
      if (wr_en && idx == pcpsr_pkg::IDX_IRQ_MASK)
        irq_mask_q <= pwdata[pcpsr_pkg::SIGN_W-1:0];
      irq_q <= |(irq_status_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // apb read path and handshake
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_mux = '0;
    mapped = 1'b1;
    case (idx)
      pcpsr_pkg::IDX_PHASE_A_COMP: rd_mux[pcpsr_pkg::CODE_W-1:0] = delay_code_q[0];  // [R15]
      pcpsr_pkg::IDX_PHASE_B_COMP: rd_mux[pcpsr_pkg::CODE_W-1:0] = delay_code_q[1];  // [R15]
      pcpsr_pkg::IDX_PHASE_C_COMP: rd_mux[pcpsr_pkg::CODE_W-1:0] = delay_code_q[2];  // [R15]
      pcpsr_pkg::IDX_POWER_SIGN:   rd_mux[pcpsr_pkg::SIGN_W-1:0] = power_sign_q;  // [R12]
      pcpsr_pkg::IDX_PATH_CFG:     rd_mux[pcpsr_pkg::CFG_W-1:0]  = path_cfg_q;
      pcpsr_pkg::IDX_IRQ_STATUS:   rd_mux[pcpsr_pkg::SIGN_W-1:0] = irq_status_q;
      pcpsr_pkg::IDX_IRQ_MASK:     rd_mux[pcpsr_pkg::SIGN_W-1:0] = irq_mask_q;
      default:                     mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end
    else if (ce)
    begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence setup_s;
    ce && psel && !penable;
  endsequence

  sequence access_s;
    psel && penable && pready_q;
  endsequence

  apb_answer_a: assert property (setup_s |=> pready_q) // [R15]
    else $error("apb setup not answered next cycle");
  fold_low_a: assert property (ce && delay_code_q[0] > 10'h17F && delay_code_q[0] < 10'h200 // [R3]
      |=> eff_delay_code_q[0] == $past(delay_code_q[0]) - 10'h080)
    else $error("code 384..511 not folded down by 128");
  fold_high_a: assert property (ce && delay_code_q[1] > 10'h23F // [R4]
      |=> eff_delay_code_q[1] >= 10'h180 && eff_delay_code_q[1] <= 10'h1FF
          && eff_delay_code_q[1][6:0] == $past(delay_code_q[1][6:0]) - 7'h40)
    else $error("code 576..1023 not folded into 384..511");
  pass_code_a: assert property (ce && (delay_code_q[2] < 10'h180 // [R1] [R2]
      || (delay_code_q[2] >= 10'h200 && delay_code_q[2] < 10'h240))
      |=> eff_delay_code_q[2] == $past(delay_code_q[2]))
    else $error("valid code altered");
  comp_upper_a: assert property (setup_s and (!pwrite && idx == pcpsr_pkg::IDX_PHASE_A_COMP) // [R5]
      |=> prdata_q[31:10] == 22'h000000 && prdata_q[9:0] == delay_code_q[0])
    else $error("compensation read wrong or upper bits nonzero");
  sign_upper_a: assert property (setup_s and (!pwrite && idx == pcpsr_pkg::IDX_POWER_SIGN) // [R12]
      |=> prdata_q[31:9] == 23'h000000)
    else $error("sign status reserved bits nonzero");
  sign_ro_a: assert property ((access_s and (ce && pwrite && !pwr_valid // [R14]
      && idx == pcpsr_pkg::IDX_POWER_SIGN)) |=> $stable(power_sign_q))
    else $error("write changed sign status");
  act_sign_a: assert property (ce && pwr_valid |=> power_sign_q[2:0] == ($past(rev_fund) // [R6] [R7]
      ? {$past(phase_pwr[2].fund_active[23]), $past(phase_pwr[1].fund_active[23]),
         $past(phase_pwr[0].fund_active[23])}
      : {$past(phase_pwr[2].total_active[23]), $past(phase_pwr[1].total_active[23]),
         $past(phase_pwr[0].total_active[23])}))
    else $error("active sign bits wrong");
  react_sign_a: assert property (ce && pwr_valid |=> power_sign_q[6:4] == // [R8]
      {$past(phase_pwr[2].fund_reactive[23]), $past(phase_pwr[1].fund_reactive[23]),
       $past(phase_pwr[0].fund_reactive[23])})
    else $error("reactive sign bits wrong");
  path1_single_a: assert property (ce && pwr_valid && path_cfg_q[2:0] == 3'h1 // [R9] [R13]
      && path_cfg_q[11:9] == 3'h0 |=> power_sign_q[3] == $past(phase_pwr[0].total_active[23]))
    else $error("path 1 sign not that of selected term");
  path_reserved_a: assert property (ce && pwr_valid && path_cfg_q[14:12] == 3'h1 // [R10] [R13]
      |=> !power_sign_q[7])
    else $error("reserved source gave negative path 2");
  path3_none_a: assert property (ce && pwr_valid && path_cfg_q[8:6] == 3'h0 // [R11]
      |=> !power_sign_q[8])
    else $error("empty path 3 reported negative");
  set_wins_a: assert property (ce && pwr_valid && (sign_d[0] != power_sign_q[0])
      |=> irq_status_q[0])
    else $error("sign change event lost");

endmodule : pcpsr_regs

`default_nettype wire

// File: tb/pcpsr_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none

module phase_cal_and_power_sign_regs_bench;
  logic                                   clk;
  logic                                   rst_n;
  logic                                   ce;
  logic                                   psel;
  logic                                   penable;
  logic                                   pwrite;
  logic [17:0]                            paddr;
  logic [31:0]                            pwdata;
  logic [31:0]                            prdata_q;
  logic                                   pready_q;
  logic                                   pslverr_q;
  pcpsr_pkg::pcpsr_phase_pwr_t [2:0]      phase_pwr;
  logic                                   pwr_valid;
  logic [2:0][9:0]                        eff_delay_code_q;
  logic [8:0]                             power_sign_q;
  logic                                   irq_q;
  int                                     n_errors = 0;
  int                                     cmp_count = 0;
  int                                     cyc = 0;
  logic [32:0]                            apb_q[$];
  logic [8:0]                             sign_q[$];
  logic                                   vld_d;
  logic [8:0]                             exp_sign;
  logic [8:0]                             exp_st;
  logic [18:0]                            cfg;

  pcpsr_regs pcpsr_regs_i (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
    .phase_pwr(phase_pwr), .pwr_valid(pwr_valid), .eff_delay_code_q(eff_delay_code_q),
    .power_sign_q(power_sign_q), .irq_q(irq_q));

  always #10 clk = ~clk;

  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  // apb master: expected {pslverr, prdata} is queued for the monitor
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] d, input logic [32:0] exp);
    apb_q.push_back(exp);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (!pready_q);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [9:0] fold(input logic [9:0] c);
    if (c >= 10'h240)
      return 10'h180 + ((c - 10'h240) % 10'h080);
    if (c >= 10'h180 && c <= 10'h1FF)
      return c - 10'h080;
    return c;
  endfunction : fold

  function automatic logic [8:0] sgn(input pcpsr_pkg::pcpsr_phase_pwr_t [2:0] pw, input logic [18:0] c);
    logic [8:0]         s;
    logic signed [25:0] sum;
    logic signed [23:0] v;
    s = '0;
    for (int p = 0; p < 3; p++)
    begin
      s[p]     = c[18] ? pw[p].fund_active[23] : pw[p].total_active[23];
      s[4 + p] = pw[p].fund_reactive[23];
    end
    for (int k = 0; k < 3; k++)
    begin
      sum = '0;
      for (int p = 0; p < 3; p++)
      begin
        case (c[9 + 3 * k +: 3])
          3'h0: v = pw[p].total_active;
          3'h2: v = pw[p].apparent;
          3'h3: v = pw[p].fund_active;
          3'h4: v = pw[p].fund_reactive;
          default: v = '0;
        endcase
        if (c[3 * k + p])
          sum = sum + v;
      end
      s[(k == 0) ? 3 : (k == 1) ? 7 : 8] = sum[25];
    end
    return s;
  endfunction : sgn

  task automatic refresh;
    pcpsr_pkg::pcpsr_phase_pwr_t [2:0] pw;
    logic [8:0]                        ns;
    for (int p = 0; p < 3; p++)
      pw[p] = {$urandom, $urandom, $urandom};
    ns = sgn(pw, cfg);
    exp_st = exp_st | (ns ^ exp_sign);
    exp_sign = ns;
    sign_q.push_back(ns);
    @(posedge clk);
    phase_pwr <= pw;
    pwr_valid <= 1'b1;
    @(posedge clk);
    pwr_valid <= 1'b0;
  endtask : refresh

  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (psel && penable && pready_q && apb_q.size() > 0)
      check("apb", {pslverr_q, prdata_q}, apb_q.pop_front());
    vld_d <= pwr_valid & ce;
    if (vld_d && sign_q.size() > 0)
      check("power_sign_q", power_sign_q, sign_q.pop_front());
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial
  begin
    logic [9:0]  codes[12];
    logic [31:0] w;
    clk = 0; rst_n = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
    phase_pwr = '0; pwr_valid = 0;
    exp_sign = '0; exp_st = '0; cfg = 19'h141FF;
    void'($urandom(92));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++)
      apb(0, 16'hE614 + 16'(i), 0, 33'h0);
    check("irq_q", irq_q, 1'b0);
    codes = '{10'h000, 10'h17F, 10'h180, 10'h1FF, 10'h200, 10'h23F, 10'h240, 10'h2BF, 10'h2C0, 10'h3FF,
              10'($urandom), 10'($urandom)};
    foreach (codes[i])
    begin
      w = $urandom;
      w[9:0] = codes[i];
      apb(1, 16'hE614 + 16'(i % 3), w, 33'h0);
      apb(0, 16'hE614 + 16'(i % 3), 0, {23'h0, codes[i]});
      check("eff_delay_code_q", eff_delay_code_q[i % 3], fold(codes[i]));
    end
    apb(0, 16'hE620, 0, {14'h0, cfg});
    for (int i = 0; i < 8; i++)
    begin
      cfg = 19'($urandom);
      cfg[11:9] = 3'(i);
      cfg[14:12] = 3'(i + 3);
      cfg[17:15] = 3'(i + 5);
      cfg[18] = i[0];
      // make the single-term and empty-path cases happen for sure
      if (i == 0)
        cfg[2:0] = 3'h1;
      if (i == 1)
        cfg[8:6] = 3'h0;
      apb(1, 16'hE620, {13'h0, cfg}, 33'h0);
      repeat (3) refresh();
    end
    apb(1, 16'hE617, 32'hFFFF_FFFF, 33'h0);
    apb(0, 16'hE617, 0, {24'h0, exp_sign});
    @(posedge clk);
    ce <= 1'b0;
    phase_pwr <= ~phase_pwr;
    pwr_valid <= 1'b1;
    @(posedge clk);
    pwr_valid <= 1'b0;
    ce <= 1'b1;
    apb(0, 16'hE617, 0, {24'h0, exp_sign});
    apb(0, 16'hE618, 0, {1'b1, 32'h0});
    apb(1, 16'hE6FF, 32'h1FF, {1'b1, 32'h0});
    apb(0, 16'hE621, 0, {24'h0, exp_st});
    repeat (2) @(posedge clk);
    check("irq_q masked", irq_q, 1'b0);
    apb(1, 16'hE622, 32'h1FF, 33'h0);
    repeat (2) @(posedge clk);
    check("irq_q", irq_q, |exp_st);
    apb(1, 16'hE621, 32'h1FF, 33'h0);
    apb(0, 16'hE621, 0, 33'h0);
    repeat (2) @(posedge clk);
    check("irq_q cleared", irq_q, 1'b0);
    // clear and sign-change event land on the same edge: the event must win
    exp_st = '0;
    fork
      apb(1, 16'hE621, 32'h1FF, 33'h0);
      begin
        @(posedge clk);
        refresh();
      end
    join
    apb(0, 16'hE621, 0, {24'h0, exp_st});
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    apb(0, 16'hE617, 0, 33'h0);
    apb(0, 16'hE615, 0, 33'h0);
    apb(0, 16'hE621, 0, 33'h0);
    check("irq_q after reset", irq_q, 1'b0);
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule : phase_cal_and_power_sign_regs_bench

`default_nettype wire
